/* File: design/lcdmux_ctrl.sv */
/*
  segment lcd multiplexing controller: mode register and 24-byte display
  ram on axi4-lite, common plate scan and digital drive levels.
  assumes: stop_req and clk_fail come from other clock logic on mclk;
  aux_ref is an asynchronous square wave near 32 khz.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lcdmux_defines.svh"

module lcdmux_ctrl (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        aux_ref,
  input  wire logic        stop_req,
  input  wire logic        clk_fail,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       common_plate,
  output logic [3:0]       common_plate_oe,
  output logic [47:4]      segment,
  output logic             bias_enable,
  output logic             bias_third_en
);
  // mode register and display ram
  logic [7:0]  mode_ff;
  logic [7:0]  ram_ff [`LCDMUX_RAM_BYTES];
  // write channel capture
  logic        aw_held_ff;
  logic [7:0]  aw_addr_ff;
  logic        w_held_ff;
  logic [7:0]  w_data_ff;
  logic        w_strb_ff;
  // scanning state
  logic        aux_s1_ff;
  logic        aux_s2_ff;
  logic        aux_s3_ff;
  logic [9:0]  slot_cnt_ff;
  logic [1:0]  plate_ff;
  logic        phase_ff;
  logic        ref_tick;
  logic        ref_valid;
  logic        run;
  logic [9:0]  slot_len;
  logic [1:0]  last_plate;
  lcdmux_pkg::lcdmux_mux_t mux_mode;

  // ram index of a bus address, or all ones when outside the ram
  function automatic logic [4:0] ram_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `LCDMUX_RAM_FIRST;
    if (a >= `LCDMUX_RAM_FIRST && a <= `LCDMUX_RAM_LAST) begin
      ram_index = d[4:0];
    end else begin
      ram_index = 5'h1F;
    end
  endfunction

  // reference ticks per slot for a frame code; zero for reserved
  function automatic logic [9:0] slot_ticks(input logic [2:0] code);
    unique case (code)
      3'b000:  slot_ticks = 10'd512;  // 64 hz
      3'b001:  slot_ticks = 10'd384;  // 85 hz
      3'b010:  slot_ticks = 10'd256;  // 128 hz
      3'b011:  slot_ticks = 10'd192;  // 171 hz
      3'b100:  slot_ticks = 10'd128;  // 256 hz
      3'b101:  slot_ticks = 10'd96;   // 341 hz
      3'b110:  slot_ticks = 10'd64;   // 512 hz
      default: slot_ticks = 10'd0;
    endcase
  endfunction

  // mode field decode
  assign mux_mode = lcdmux_pkg::lcdmux_mux_t'(
    mode_ff[`LCDMUX_MUX_HI:`LCDMUX_MUX_LO]);
  assign slot_len = slot_ticks(mode_ff[`LCDMUX_FRM_HI:`LCDMUX_FRM_LO]);

  // last active plate index per ratio
  always_comb begin
    unique case (mux_mode)
      lcdmux_pkg::LCDMUX_MUX_QUAD:  last_plate = 2'd3;
      lcdmux_pkg::LCDMUX_MUX_ONE:   last_plate = 2'd0;
      lcdmux_pkg::LCDMUX_MUX_TWO:   last_plate = 2'd1;
      lcdmux_pkg::LCDMUX_MUX_THREE: last_plate = 2'd2;
    endcase
  end

  // driver runs only with a valid source, valid rate, no stop or failure
  assign run = ref_valid && (slot_len != 10'd0) && !stop_req && !clk_fail;

  // aux reference synchroniser and rising edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aux_s1_ff <= 1'b0;
      aux_s2_ff <= 1'b0;
      aux_s3_ff <= 1'b0;
    end else begin
      aux_s1_ff <= aux_ref;
      aux_s2_ff <= aux_s1_ff;
      aux_s3_ff <= aux_s2_ff;
    end
  end

  lcdmux_refgen u_refgen (
    .mclk         (mclk),
    .resetn       (resetn),
    .div_sel      (mode_ff[`LCDMUX_DIV_HI:`LCDMUX_DIV_LO]),
    .aux_ref_tick (aux_s2_ff && !aux_s3_ff),
    .ref_tick     (ref_tick),
    .ref_valid    (ref_valid)
  );

  // slot timer, plate scan and ac phase; each slot lasts one base period
  // so a full scan takes plates x base period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slot_cnt_ff <= 10'd0;
      plate_ff    <= 2'd0;
      phase_ff    <= 1'b0;
    end else if (!run) begin
      slot_cnt_ff <= 10'd0;
      plate_ff    <= 2'd0;
      phase_ff    <= 1'b0;
    end else if (plate_ff > last_plate) begin
      // a ratio cut mid-scan restarts from the first plate
      slot_cnt_ff <= 10'd0;
      plate_ff    <= 2'd0;
    end else if (ref_tick) begin
      if (slot_cnt_ff >= slot_len - 10'd1) begin
        slot_cnt_ff <= 10'd0;
        if (plate_ff >= last_plate) begin
          plate_ff <= 2'd0;
          phase_ff <= !phase_ff;  // frame inversion keeps dc off the panel
        end else begin
          plate_ff <= plate_ff + 2'd1;
        end
      end else begin
        slot_cnt_ff <= slot_cnt_ff + 10'd1;
      end
    end
  end

  // segment and common drive, grounded whenever not running; reset leaves the plate drivers off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      segment         <= '0;
      common_plate    <= 4'h0;
      common_plate_oe <= 4'h0;
      bias_enable     <= 1'b0;
      bias_third_en   <= 1'b0;
    end else if (!run) begin
      segment         <= '0;
      common_plate    <= 4'h0;
      common_plate_oe <= 4'hF;
      bias_enable     <= 1'b0;
      bias_third_en   <= 1'b0;
    end else begin
      for (int s = 4; s <= `LCDMUX_SEGS; s++) begin
        // byte (s-1)/8 of the plate group, bit (s-1)%8; a set
        // bit drives the segment opposite to the selected plate
        segment[s] <= ram_ff[`LCDMUX_PLATE_BYTES * plate_ff + (s - 1) / 8]
                      [(s - 1) % 8] ^ !phase_ff;
      end
      for (int p = 0; p < 4; p++) begin
        common_plate[p]    <= (2'(p) == plate_ff) ? !phase_ff : phase_ff;
        common_plate_oe[p] <= (2'(p) <= last_plate);
      end
      bias_enable   <= 1'b1;
      bias_third_en <= (mux_mode != lcdmux_pkg::LCDMUX_MUX_TWO);
    end
  end

  // axi write channels taken in either order
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_strb_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr[9:2];  // word index
      end else if (aw_held_ff && w_held_ff) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_strb_ff <= s_axi_wstrb[0];
      end else if (aw_held_ff && w_held_ff) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // ready while nothing held and no response pending
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_bvalid &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_ff && !s_axi_bvalid &&
                       !(s_axi_wvalid && s_axi_wready);
    end
  end

  // mode register commit and write response
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_ff      <= `LCDMUX_MODE_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LCDMUX_RESP_OKAY;
    end else if (aw_held_ff && w_held_ff) begin
      if (aw_addr_ff == `LCDMUX_MODE_OFFS && w_strb_ff) begin
        mode_ff <= w_data_ff;
      end
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_ff == `LCDMUX_MODE_OFFS ||
                       aw_addr_ff == `LCDMUX_STAT_OFFS ||
                       ram_index(aw_addr_ff) != 5'h1F) ?
                      `LCDMUX_RESP_OKAY : `LCDMUX_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // display ram has no reset; every byte is plain storage
  always_ff @(posedge mclk) begin
    if (aw_held_ff && w_held_ff && w_strb_ff &&
        ram_index(aw_addr_ff) != 5'h1F) begin
      ram_ff[ram_index(aw_addr_ff)] <= w_data_ff;
    end
  end

  // read channel: one cycle to answer, held until taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LCDMUX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `LCDMUX_RESP_OKAY;
      if (s_axi_araddr[9:2] == `LCDMUX_MODE_OFFS) begin
        s_axi_rdata <= {24'h00_0000, mode_ff};
      end else if (s_axi_araddr[9:2] == `LCDMUX_STAT_OFFS) begin
        s_axi_rdata <= {28'h000_0000, phase_ff, plate_ff, run};
      end else if (ram_index(s_axi_araddr[9:2]) != 5'h1F) begin
        s_axi_rdata <= {24'h00_0000,
                        ram_ff[ram_index(s_axi_araddr[9:2])]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `LCDMUX_RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // assertions
  chk_stop_grounds: assert property (
    @(posedge mclk) disable iff (!resetn)
    stop_req |=> (segment == '0 && common_plate == 4'h0))
    else $error("outputs not grounded during stop");

  chk_fail_grounds: assert property (
    @(posedge mclk) disable iff (!resetn)
    clk_fail |=> (segment == '0 && !bias_enable))
    else $error("outputs not grounded on clock failure");

  chk_bias_off: assert property (
    @(posedge mclk) disable iff (!resetn)
    !run |=> !bias_enable)
    else $error("bias divider enabled while driver off");

  chk_half_bias: assert property (
    @(posedge mclk) disable iff (!resetn)
    (run && mux_mode == lcdmux_pkg::LCDMUX_MUX_TWO) |=> !bias_third_en)
    else $error("third bias driven in half ratio");

  chk_plate_range: assert property (
    @(posedge mclk) disable iff (!resetn)
    plate_ff <= last_plate || $changed(mode_ff))
    else $error("scan beyond active plates");

  chk_reserved_off: assert property (
    @(posedge mclk) disable iff (!resetn)
    (mode_ff[`LCDMUX_FRM_HI:`LCDMUX_FRM_LO] == 3'b111) |=> !bias_enable)
    else $error("reserved rate code not treated as off");

  chk_mode_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    (aw_held_ff && w_held_ff && w_strb_ff &&
     aw_addr_ff == `LCDMUX_MODE_OFFS) |=> mode_ff == $past(w_data_ff))
    else $error("mode register write lost");

  sequence slot_end_s;
    run && ref_tick && slot_cnt_ff == slot_len - 10'd1;
  endsequence
  chk_scan_step: assert property (
    @(posedge mclk) disable iff (!resetn)
    (slot_end_s ##0 plate_ff < last_plate ##1 run) |->
      plate_ff == $past(plate_ff) + 2'd1)
    else $error("scan did not advance one plate");
endmodule
`default_nettype wire

/* File: design/lcdmux_defines.svh */
/*
  register offsets, field positions and timing counts of the segment lcd
  multiplexing controller.
  assumes: included by bare name from design files only.
*/
`ifndef LCDMUX_DEFINES_SVH
`define LCDMUX_DEFINES_SVH

// register indices; the axi4-lite byte address is four times the index
`define LCDMUX_MODE_OFFS      8'hDC
`define LCDMUX_RAM_FIRST      8'hE0
`define LCDMUX_RAM_LAST       8'hF7
`define LCDMUX_STAT_OFFS      8'hD8
`define LCDMUX_PLATE_BYTES    6
`define LCDMUX_RAM_BYTES      24
// fields of lcd_mode_control
`define LCDMUX_MUX_HI         7
`define LCDMUX_MUX_LO         6
`define LCDMUX_DIV_HI         5
`define LCDMUX_DIV_LO         3
`define LCDMUX_FRM_HI         2
`define LCDMUX_FRM_LO         0
`define LCDMUX_MODE_RESET     8'h00
// slice length in reference clocks: 32768 / base rate
`define LCDMUX_REF_HZ         32768
`define LCDMUX_SEGS           48
// axi responses
`define LCDMUX_RESP_OKAY      2'b00
`define LCDMUX_RESP_SLVERR    2'b10

`endif

/* File: design/lcdmux_pkg.sv */
/*
  types shared by the lcd multiplexing controller.
  assumes: nothing beyond a systemverilog compiler.
*/
package lcdmux_pkg;
  typedef enum logic [1:0] {
    LCDMUX_MUX_QUAD,
    LCDMUX_MUX_ONE,
    LCDMUX_MUX_TWO,
    LCDMUX_MUX_THREE
  } lcdmux_mux_t;
endpackage

/* File: design/lcdmux_refgen.sv */
/*
  reference clock generator: turns the divider code into a one-cycle
  enable at the main clock divided by 32, 64, 128 or 256, or passes the
  auxiliary reference enable.
  assumes: aux_ref_tick is already on mclk, one cycle wide.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lcdmux_defines.svh"

module lcdmux_refgen (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [2:0] div_sel,
  input  wire logic       aux_ref_tick,
  output logic            ref_tick,
  output logic            ref_valid
);
  logic [7:0] pre_ff;
  logic [7:0] limit;

  // divide factor from the code; ref_valid low marks off or reserved, limit zero also for aux
  always_comb begin
    limit     = 8'h00;
    ref_valid = 1'b1;
    unique case (div_sel)
      3'b001:  limit = 8'h00;
      3'b011:  limit = 8'h1F;
      3'b100:  limit = 8'h3F;
      3'b101:  limit = 8'h7F;
      3'b110:  limit = 8'hFF;
      default: ref_valid = 1'b0;
    endcase
  end

  // prescaler counts mclk cycles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= 8'h00;
    end else if (!ref_valid || div_sel == 3'b001 || pre_ff >= limit) begin
      pre_ff <= 8'h00;
    end else begin
      pre_ff <= pre_ff + 8'h01;
    end
  end

  assign ref_tick = !ref_valid ? 1'b0 :
                    (div_sel == 3'b001) ? aux_ref_tick : (pre_ff == limit);
endmodule
`default_nettype wire

/* File: tb/lcdmux_panel.sv */
/*
  passive panel model: flags when every line sits at ground.
  assumes: lines come straight from the controller pins.
*/
`timescale 1ns/100ps
`default_nettype none
module lcdmux_panel (
  input  wire logic [3:0]  common_plate,
  input  wire logic [3:0]  common_plate_oe,
  input  wire logic [47:4] segment,
  input  wire logic        bias_enable,
  output logic             grounded
);
  // no bias across any element while all lines are tied low
  assign grounded = common_plate === 4'h0 && segment === 44'h000_0000_0000
    && common_plate_oe === 4'hF && bias_enable === 1'h0;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  self-checking bench of the lcd multiplexing controller.
  assumes: aux_ref faster than real so slots stay short in simulation.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        mclk, resetn, aux_ref, stop_req, clk_fail;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [7:0]  d;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, common_plate, common_plate_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, q;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, bias_enable, bias_third_en;
  logic        grounded;
  logic [47:4] segment;
  int          mismatches, comparisons, c, e;
  logic [3:0]  oe_x [4] = '{4'hF, 4'h1, 4'h3, 4'h7};
  int          tk [7] = '{512, 384, 256, 192, 128, 96, 64};
  logic [7:0]  off_x [4] = '{8'h50, 8'h78, 8'h4F, 8'h40};

  lcdmux_ctrl lcdmux_ctrl_i (.mclk, .resetn, .aux_ref, .stop_req,
    .clk_fail, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .common_plate,
    .common_plate_oe, .segment, .bias_enable, .bias_third_en);
  lcdmux_panel lcdmux_panel_i (.common_plate, .common_plate_oe, .segment,
    .bias_enable, .grounded);

  // main clock and a fast free-running auxiliary reference
  always #5 mclk = ~mclk;
  always #41.5 aux_ref = ~aux_ref;

  // counts one comparison and reports a miss
  task ck(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // axi4-lite write of one byte lane, response left in r
  task wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    ck(n < 100, "write hung");
  endtask

  // axi4-lite read, byte in d and response in r
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 100);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    ck(n < 100 && s_axi_rdata[31:8] === 24'h00_0000, "read");
  endtask

  // cycles until the drive pattern next changes
  task chg(output int n);
    logic [47:0] v;
    n = 0;
    v = {common_plate, segment};
    while ({common_plate, segment} === v && n < 20000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // length of one full slot between two changes
  task slot;
    chg(c);
    chg(c);
  endtask

  task t_regs;
    rd(8'hDC);
    ck(d === 8'h00 && r === 2'h0 && grounded, "reset state");
    wr(8'hDC, 8'h5A);
    rd(8'hDC);
    ck(d === 8'h5A, "mode readback");
    wr(8'h40, 8'h11);
    ck(r === 2'h2, "unmapped write");
    rd(8'h40);
    ck(r === 2'h2 && d === 8'h00, "unmapped read");
    for (int i = 0; i < 24; i++) wr(8'hE0 + i[7:0], {i[4:0], 3'h5});
    for (int i = 0; i < 24; i++) begin
      rd(8'hE0 + i[7:0]);
      ck(d === {i[4:0], 3'h5}, "ram storage");
    end
    // a write with its byte lane off answers okay and stores nothing
    s_axi_wstrb <= 4'h0;
    wr(8'hE0, 8'hFF);
    ck(r === 2'h0, "strobe off response");
    s_axi_wstrb <= 4'h1;
    rd(8'hE0);
    ck(d === 8'h05, "strobe off keeps byte");
  endtask

  task t_map;
    wr(8'hE0, 8'h08);
    wr(8'hE1, 8'h01);
    wr(8'hE5, 8'h01);
    wr(8'hE7, 8'h00);
    wr(8'hDC, 8'h4E);
    slot;
    ck(segment[4] === ~segment[5], "s4 position");
    ck(segment[41] === ~segment[42], "s41 position");
    ck(segment[9] === ~common_plate[0], "element on");
    ck(segment[10] === common_plate[0], "element off");
    for (int m = 0; m < 4; m++) begin
      wr(8'hDC, {m[1:0], 6'h0E});
      slot;
      ck(common_plate_oe === oe_x[m], "plates");
      ck(bias_third_en === (m != 2) && bias_enable, "bias");
    end
  endtask

  task t_scan;
    wr(8'hDC, 8'h8E);
    slot;
    q = 2'h3;
    for (int k = 0; k < 3; k++) begin
      rd(8'hD8);
      ck(d[2:1] !== q && d[2:1] < 2'h2, "scan order");
      ck(segment[9] === ((d[2:1] !== 2'h0) ^ d[3]), "plate data");
      q = d[2:1];
      chg(c);
    end
  endtask

  task t_rates;
    for (int f = 0; f < 7; f++) begin
      wr(8'hDC, {5'h09, f[2:0]});
      slot;
      e = tk[f] * 83 / 10;
      ck(c >= e - 2 && c <= e + 2, "frame rate");
    end
    for (int v = 3; v < 7; v++) begin
      wr(8'hDC, {2'h1, v[2:0], 3'h6});
      slot;
      ck(c === (1 << (v + 8)), "divider");
    end
  endtask

  task t_off;
    wr(8'hDC, 8'h4E);
    chg(c);
    stop_req <= 1'h1;
    repeat (2) @(posedge mclk);
    ck(grounded, "stop grounds");
    stop_req <= 1'h0;
    chg(c);
    clk_fail <= 1'h1;
    repeat (2) @(posedge mclk);
    ck(grounded, "failure grounds");
    clk_fail <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      chg(c);
      ck(grounded === 1'h0, "running");
      wr(8'hDC, off_x[k]);
      repeat (3) @(posedge mclk);
      ck(grounded, "reserved code");
      wr(8'hDC, 8'h4E);
    end
  endtask

  // prints counts and the verdict, then stops
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reset, then every scenario in turn
  initial begin
    mclk = 1'h0;
    aux_ref = 1'h0;
    resetn = 1'h0;
    stop_req = 1'h0;
    clk_fail = 1'h0;
    s_axi_awaddr = 10'h000;
    s_axi_araddr = 10'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    repeat (10) @(posedge mclk);
    resetn <= 1'h1;
    repeat (2) @(posedge mclk);
    t_regs;
    t_map;
    t_scan;
    t_rates;
    t_off;
    end_sim;
  end

  // watchdog well beyond the expected run length
  initial begin
    #2000000;
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
